/* logic/adc_evt_pkg.sv */
// Package of constants for the converter event, window and flag block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package adc_evt_pkg;
  // Register byte offsets.
  localparam logic [7:0] primary_control_off = 8'h00;
  localparam logic [7:0] window_control_off = 8'h04;
  localparam logic [7:0] interrupt_enable_off = 8'h08;
  localparam logic [7:0] interrupt_flag_off = 8'h0C;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] debug_control_off = 8'h14;
  localparam logic [7:0] command_off = 8'h18;
  localparam logic [7:0] result_off = 8'h1C;
  localparam logic [7:0] sample_off = 8'h20;
  localparam logic [7:0] low_threshold_off = 8'h24;
  localparam logic [7:0] high_threshold_off = 8'h28;
  // Field positions in the primary control register.
  localparam int standby_run_pos = 7;
  localparam int low_latency_pos = 5;
  localparam int enable_pos = 0;
  // Field positions in the window control register.
  localparam int window_source_pos = 6;
  // Flag and enable bit positions.
  localparam int result_ready_pos = 0;
  localparam int sample_ready_pos = 1;
  localparam int window_match_pos = 2;
  localparam int result_overrun_pos = 3;
  localparam int sample_overrun_pos = 4;
  localparam int trigger_overrun_pos = 5;
  // Value of the start field that selects event triggering.
  localparam logic [2:0] start_event_trigger = 3'h4;
  // Window comparison modes.
  localparam logic [2:0] win_off = 3'h0;
  localparam logic [2:0] win_above = 3'h1;
  localparam logic [2:0] win_below = 3'h2;
  localparam logic [2:0] win_inside = 3'h3;
  localparam logic [2:0] win_outside = 3'h4;
  // Reset values.
  localparam logic [7:0] reg_reset = 8'h00;
  // Bus responses.
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : adc_evt_pkg

/* logic/adc_window_event_irq_ctrl.sv */
// Window comparator, event outputs, interrupt flags, sleep and debug halt control.
// Assumes the conversion core gives one-cycle done strobes synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module adc_window_event_irq_ctrl #(
  parameter int data_width = 16 // Not used; compared values are fixed at 16 bits.
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Conversion core side.
  input wire logic sample_done,
  input wire logic [15:0] sample_value,
  input wire logic result_done,
  input wire logic [31:0] result_value,
  input wire logic software_start,
  input wire logic start_event_in,
  output logic conversion_start,
  output logic conversion_abort,
  output logic analog_keep_on,
  output logic converter_halted,
  // System state.
  input wire logic sleep_idle,
  input wire logic sleep_standby,
  input wire logic sleep_powerdown,
  input wire logic debug_halt,
  // Events and interrupt vectors.
  output logic result_ready_event,
  output logic sample_ready_event,
  output logic window_match_event,
  output logic result_ready_irq,
  output logic sample_ready_irq,
  output logic error_irq
);
  import adc_evt_pkg::*;

  // Whole state of the block in one record.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic [7:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] primary_control_reg;
    logic [7:0] window_control_reg;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] interrupt_flag_reg;
    logic debug_control_reg;
    logic [2:0] start_mode;
    logic [15:0] window_low_threshold;
    logic [15:0] window_high_threshold;
    logic [31:0] result_data;
    logic [15:0] sample_data;
    logic result_unread;
    logic sample_unread;
    logic busy;
    logic start_event_prev;
    logic conv_start;
    logic conv_abort;
    logic keep_on;
    logic halted;
    logic res_evt;
    logic samp_evt;
    logic win_evt;
    logic res_irq;
    logic samp_irq;
    logic err_irq;
  } state_t;

  state_t st; // Registered state.
  state_t next_st; // Next state.

  // Window comparison used for both sources.
  function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] v,
                                      input logic [15:0] lo, input logic [15:0] hi);
    case (mode)
      win_above: window_hit = v > lo;
      win_below: window_hit = v < hi;
      win_inside: window_hit = (v > lo) && (v < hi);
      win_outside: window_hit = (v < lo) || (v > hi);
      default: window_hit = 1'b0; // Mode zero or unused keeps the comparator off.
    endcase
  endfunction

  logic [2:0] win_mode; // Active window mode.
  logic win_src_sample; // High selects the sample register as source.
  logic stopped; // Converter may take no new start.
  logic start_req; // A start request this cycle.
  logic cmp_now; // A comparison happens this cycle.
  logic match; // Window matched this cycle.
  logic [7:0] set_flags; // Flags raised this cycle.
  logic [7:0] wr_clear; // Flags cleared by software this cycle.
  logic do_write; // A register write completes.
  logic do_read; // A register read is taken.
  logic [31:0] rd_mux; // Read data for the taken address.
  logic rd_ok; // Read address is mapped.
  logic [7:0] flags_after; // Flags after set and clear.

  assign win_mode = st.window_control_reg[2:0];
  assign win_src_sample = st.window_control_reg[window_source_pos];

  // Next state logic; the whole block advances only with the clock enable.
  always_comb begin
    next_st = st;
    // Halting for debug or standby waits until the running conversion ends; power-down aborts it.
    stopped = (sleep_standby && !st.primary_control_reg[standby_run_pos])
              || (debug_halt && !st.debug_control_reg)
              || sleep_powerdown;
    start_req = 1'b0;
    if (st.primary_control_reg[enable_pos] && !stopped) begin
      // The edge detector looks at the raw event level, so short pulses are
      // lost if they fall between clock edges; that is the price of one clock.
      if (st.start_mode == start_event_trigger) begin
        start_req = start_event_in && !st.start_event_prev;
      end else begin
        start_req = software_start && !sleep_idle && !sleep_standby;
      end
    end
    next_st.start_event_prev = start_event_in;
    next_st.conv_start = start_req && !st.busy;
    next_st.conv_abort = sleep_powerdown && st.busy;
    // Only power-down cuts a conversion short; idle and standby let it end.
    if (sleep_powerdown) begin
      next_st.busy = 1'b0;
    end else if (start_req && !st.busy) begin
      next_st.busy = 1'b1;
    end else if (result_done) begin
      next_st.busy = 1'b0;
    end
    next_st.halted = stopped && !st.busy;
    next_st.keep_on = st.primary_control_reg[low_latency_pos]
                      && (!sleep_standby || st.primary_control_reg[standby_run_pos]);
    // Compare the sample after each conversion, the result once at the end.
    cmp_now = win_src_sample ? sample_done : result_done;
    match = cmp_now && window_hit(win_mode, win_src_sample ? sample_value :
                                  result_value[15:0], st.window_low_threshold,
                                  st.window_high_threshold);
    set_flags = 8'h00;
    set_flags[result_ready_pos] = result_done;
    set_flags[sample_ready_pos] = sample_done;
    set_flags[window_match_pos] = match;
    set_flags[result_overrun_pos] = result_done && st.result_unread;
    set_flags[sample_overrun_pos] = sample_done && st.sample_unread;
    set_flags[trigger_overrun_pos] = start_req && st.busy;
    // Events carry exactly the flag set conditions, one cycle long.
    next_st.res_evt = set_flags[result_ready_pos];
    next_st.samp_evt = set_flags[sample_ready_pos];
    next_st.win_evt = set_flags[window_match_pos];
    if (result_done) begin
      next_st.result_data = result_value;
    end
    if (sample_done) begin
      next_st.sample_data = sample_value;
    end
    // Bus write channel: address and data captured independently.
    if (s_axi_awvalid && st.awready) begin
      next_st.awaddr = s_axi_awaddr;
      next_st.aw_held = 1'b1;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.w_held = 1'b1;
      next_st.wready = 1'b0;
    end
    do_write = st.aw_held && st.w_held && !st.bvalid;
    wr_clear = 8'h00;
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = resp_okay;
      case (st.awaddr)
        primary_control_off: begin
          if (st.wstrb[0]) next_st.primary_control_reg = st.wdata[7:0] & 8'hA1;
        end
        window_control_off: begin
          if (st.wstrb[0]) next_st.window_control_reg = st.wdata[7:0] & 8'h47;
        end
        interrupt_enable_off: begin
          if (st.wstrb[0]) next_st.interrupt_enable_reg = st.wdata[7:0] & 8'h3F;
        end
        interrupt_flag_off: begin
          if (st.wstrb[0]) wr_clear = st.wdata[7:0];
        end
        debug_control_off: begin
          if (st.wstrb[0]) next_st.debug_control_reg = st.wdata[0];
        end
        command_off: begin
          if (st.wstrb[0]) next_st.start_mode = st.wdata[2:0];
        end
        low_threshold_off: begin
          if (st.wstrb[0]) next_st.window_low_threshold[7:0] = st.wdata[7:0];
          if (st.wstrb[1]) next_st.window_low_threshold[15:8] = st.wdata[15:8];
        end
        high_threshold_off: begin
          if (st.wstrb[0]) next_st.window_high_threshold[7:0] = st.wdata[7:0];
          if (st.wstrb[1]) next_st.window_high_threshold[15:8] = st.wdata[15:8];
        end
        status_off, result_off, sample_off: begin
          // Read-only registers ignore writes.
        end
        default: next_st.bresp = resp_slverr;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    // Bus read channel.
    rd_ok = 1'b1;
    case (s_axi_araddr)
      primary_control_off: rd_mux = {24'h000000, st.primary_control_reg};
      window_control_off: rd_mux = {24'h000000, st.window_control_reg};
      interrupt_enable_off: rd_mux = {24'h000000, st.interrupt_enable_reg};
      interrupt_flag_off: rd_mux = {24'h000000, st.interrupt_flag_reg};
      status_off: rd_mux = {31'h0, st.busy};
      debug_control_off: rd_mux = {31'h0, st.debug_control_reg};
      command_off: rd_mux = {29'h0, st.start_mode};
      result_off: rd_mux = st.result_data;
      sample_off: rd_mux = {16'h0000, st.sample_data};
      low_threshold_off: rd_mux = {16'h0000, st.window_low_threshold};
      high_threshold_off: rd_mux = {16'h0000, st.window_high_threshold};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
    do_read = s_axi_arvalid && st.arready;
    if (do_read) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_mux;
      next_st.rresp = rd_ok ? resp_okay : resp_slverr;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    // Reading the data registers marks them as seen; a new value wins.
    if (do_read && s_axi_araddr == result_off) next_st.result_unread = 1'b0;
    if (result_done) next_st.result_unread = 1'b1;
    if (do_read && s_axi_araddr == sample_off) next_st.sample_unread = 1'b0;
    if (sample_done) next_st.sample_unread = 1'b1;
    // A set in the same cycle as a clear wins, so no event is lost.
    flags_after = (st.interrupt_flag_reg & ~wr_clear) | set_flags;
    next_st.interrupt_flag_reg = flags_after;
    // Requests stay high while the flag and its enable are both high.
    next_st.res_irq = |(flags_after & st.interrupt_enable_reg &
                        (8'h01 | (win_src_sample ? 8'h00 : 8'h04)));
    next_st.samp_irq = |(flags_after & st.interrupt_enable_reg &
                         (8'h02 | (win_src_sample ? 8'h04 : 8'h00)));
    next_st.err_irq = |(flags_after & st.interrupt_enable_reg & 8'h38);
  end

  // State register with synchronous active-low reset and clock enable.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign conversion_start = st.conv_start;
  assign conversion_abort = st.conv_abort;
  assign analog_keep_on = st.keep_on;
  assign converter_halted = st.halted;
  assign result_ready_event = st.res_evt;
  assign sample_ready_event = st.samp_evt;
  assign window_match_event = st.win_evt;
  assign result_ready_irq = st.res_irq;
  assign sample_ready_irq = st.samp_irq;
  assign error_irq = st.err_irq;

  // Checks on the flag, event, request, abort and start behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn || !clk_en);

  res_event_pulse_a: assert property (result_done |=> result_ready_event ##1
    (result_ready_event == $past(result_done))) else $error("result event wrong");
  res_flag_set_a: assert property (result_done |=> st.interrupt_flag_reg[0])
    else $error("result flag not set");
  samp_flag_set_a: assert property (sample_done |=> st.interrupt_flag_reg[1])
    else $error("sample flag not set");
  res_ovr_a: assert property (result_done && st.result_unread |=> st.interrupt_flag_reg[3])
    else $error("result overrun missed");
  samp_ovr_a: assert property (sample_done && st.sample_unread |=> st.interrupt_flag_reg[4])
    else $error("sample overrun missed");
  trig_ovr_a: assert property (start_req && st.busy |=> st.interrupt_flag_reg[5])
    else $error("trigger overrun missed");
  mode_off_a: assert property (win_mode == win_off |=> !window_match_event)
    else $error("match with comparator off");
  err_irq_level_a: assert property (st.interrupt_flag_reg[5] && st.interrupt_enable_reg[5]
    && !do_write |=> error_irq) else $error("error request dropped");
  abort_busy_a: assert property (sleep_powerdown |=> !st.busy)
    else $error("power-down did not abort");
  start_mode_a: assert property (conversion_start && st.start_mode == start_event_trigger
    |-> $past(start_event_in)) else $error("start without event");

  res_cov_c: cover property (result_done ##1 result_ready_irq);
  win_cov_c: cover property (window_match_event);
  ovr_cov_c: cover property (error_irq);
  halt_cov_c: cover property (converter_halted);
endmodule // adc_window_event_irq_ctrl

`default_nettype wire

/* verification/conv_core_model.sv */
// Behavioural conversion core: answers each start taken while idle and not aborted with a sample and a result.
// Assumes one-cycle start and abort strobes synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic conversion_start,
  input wire logic conversion_abort,
  input wire logic [15:0] next_value,
  output logic sample_done,
  output logic [15:0] sample_value,
  output logic result_done,
  output logic [31:0] result_value
);
  // Long enough that a second start can land while busy.
  localparam int conv_cycles = 8;
  int count;
  logic [15:0] held;
  // One conversion at a time; an abort drops it with no done strobe.
  always @(posedge ref_clk) begin
    sample_done <= 0;
    result_done <= 0;
    // Data lines flip every cycle outside the done, reset and abort cycles, so stale data never passes.
    sample_value <= ~sample_value;
    result_value <= ~result_value;
    if (!resetn || conversion_abort) begin
      count <= 0;
      held <= 16'h0000;
      sample_value <= 16'h0000;
      result_value <= 32'h0000_0000;
    end else if (conversion_start && count == 0) begin
      count <= conv_cycles;
      held <= next_value;
    end else if (count == 1) begin
      count <= 0;
      sample_done <= 1;
      result_done <= 1;
      sample_value <= held;
      // Stands in for an accumulated value, so its low half differs from the sample.
      result_value <= {~held, held + 16'h0080};
    end else if (count > 1) begin
      count <= count - 1;
    end
  end
endmodule // conv_core_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the converter window, event, flag, sleep and debug block.
// Assumes the conversion core model and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_evt_pkg::*;
  logic ref_clk = 0;
  logic resetn = 0;
  logic clk_en = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, result_value, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sample_done, result_done, conversion_start, conversion_abort;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic analog_keep_on, converter_halted, result_ready_event, sample_ready_event;
  logic window_match_event, result_ready_irq, sample_ready_irq, error_irq;
  logic software_start = 0, start_event_in = 0, sleep_idle = 0, sleep_standby = 0;
  logic sleep_powerdown = 0, debug_halt = 0;
  logic [15:0] sample_value, next_value = 0, v, cv;
  logic [15:0] vals [6] = '{16'h0100, 16'h0101, 16'h0200, 16'h01FF, 16'h0000, 16'h0000};
  localparam logic [15:0] lo = 16'h0100;
  localparam logic [15:0] hi = 16'h0200;
  logic [2:0] notes [$]; // Expected {window, sample, result} event triples.
  int n_fail = 0, n_compared = 0, n_starts = 0, n_aborts = 0, k, seed;

  adc_window_event_irq_ctrl dut (.ref_clk, .resetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_done, .sample_value, .result_done,
    .result_value, .software_start, .start_event_in, .conversion_start, .conversion_abort,
    .analog_keep_on, .converter_halted, .sleep_idle, .sleep_standby, .sleep_powerdown,
    .debug_halt, .result_ready_event, .sample_ready_event, .window_match_event,
    .result_ready_irq, .sample_ready_irq, .error_irq);
  conv_core_model core (.ref_clk, .resetn, .conversion_start, .conversion_abort, .next_value,
    .sample_done, .sample_value, .result_done, .result_value);

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Every event pulse takes the oldest note; a pulse held twice finds no note.
  always @(posedge ref_clk) begin
    if (resetn && {window_match_event, sample_ready_event, result_ready_event} !== 3'h0) begin
      check({window_match_event, sample_ready_event, result_ready_event},
        notes.size() ? 32'(notes.pop_front()) : 32'hFFFF_FFFF);
    end
    n_starts += int'(conversion_start);
    n_aborts += int'(conversion_abort);
  end

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge ref_clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge ref_clk);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, rd);
    check(rd, exp);
  endtask

  // One conversion started by software or by an event edge, then its completion.
  task automatic convert(input logic [15:0] val, input logic [2:0] ev, input logic by_ev);
    next_value <= val;
    notes.push_back(ev);
    if (by_ev) start_event_in <= 1;
    else software_start <= 1;
    @(posedge ref_clk);
    software_start <= 0;
    start_event_in <= 0;
    do @(posedge ref_clk); while (result_ready_event !== 1'b1);
    @(posedge ref_clk);
  endtask

  // Reading both values clears their unread marks, so no overrun follows.
  task automatic tidy();
    rd_reg(result_off, rd);
    rd_reg(sample_off, rd);
    wr(interrupt_flag_off, 32'h3F);
    repeat (2) @(posedge ref_clk);
  endtask

  function automatic logic hit(input logic [2:0] m, input logic [15:0] x);
    case (m)
      win_above: return x > lo;
      win_below: return x < hi;
      win_inside: return x > lo && x < hi;
      default: return x < lo || x > hi;
    endcase
  endfunction

  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cut a hang short well after the tests should have finished.
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end

  initial begin
    seed = 8;
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    chk_reg(interrupt_flag_off, 32'h0);
    rd_reg(8'h40, rd);
    check(resp, resp_slverr);
    wr(8'h40, 32'h0);
    check(resp, resp_slverr);
    wr(low_threshold_off, 32'(lo));
    check(resp, resp_okay);
    wr(high_threshold_off, 32'(hi));
    wr(interrupt_enable_off, 32'h3F);
    wr(primary_control_off, 32'h1);
    $display("test setup done");
    // All four comparing modes on both sources; on the sample source thresholds hit exactly and missed by one.
    for (int s = 0; s < 2; s++) begin
      for (int m = 1; m <= 4; m++) begin
        for (int i = 0; i < 6; i++) begin
          vals[5] = 16'($random(seed));
          v = vals[i];
          cv = s ? v : v + 16'h0080;
          wr(window_control_off, 32'(s << window_source_pos | m));
          convert(v, {hit(3'(m), cv), 2'h3}, 0);
          chk_reg(interrupt_flag_off, 32'({hit(3'(m), cv), 2'h3}));
          check({sample_ready_irq, result_ready_irq}, 32'h3);
          chk_reg(result_off, {~v, v + 16'h0080});
          chk_reg(sample_off, 32'(v));
          wr(interrupt_flag_off, 32'h3F);
          repeat (2) @(posedge ref_clk);
          check({error_irq, sample_ready_irq, result_ready_irq}, 32'h0);
        end
      end
    end
    $display("test window done");
    // Window match alone routes to the vector of its source.
    wr(interrupt_enable_off, 32'h4);
    for (int s = 0; s < 2; s++) begin
      wr(window_control_off, 32'(s << window_source_pos | win_outside));
      convert(16'h0000, 3'h7, 0);
      check({sample_ready_irq, result_ready_irq}, s ? 32'h2 : 32'h1);
      tidy();
    end
    $display("test routing done");
    wr(window_control_off, 32'h0);
    wr(interrupt_enable_off, 32'h38);
    convert(16'h0123, 3'h3, 0);
    convert(16'h0456, 3'h3, 0);
    wr(interrupt_flag_off, 32'h0);
    chk_reg(interrupt_flag_off, 32'h1B);
    check(error_irq, 32'h1);
    tidy();
    // A second start while busy is flagged as a trigger overrun, not issued.
    k = n_starts;
    software_start <= 1;
    @(posedge ref_clk);
    software_start <= 0;
    repeat (3) @(posedge ref_clk);
    convert(16'h0001, 3'h3, 0);
    check(n_starts - k, 32'h1);
    chk_reg(interrupt_flag_off, 32'h23);
    check(error_irq, 32'h1);
    tidy();
    $display("test overrun done");
    wr(command_off, 32'(start_event_trigger));
    k = n_starts;
    convert(16'h0011, 3'h3, 1);
    sleep_idle <= 1;
    convert(16'h0022, 3'h3, 1);
    sleep_idle <= 0;
    check(n_starts - k, 32'h2);
    wr(primary_control_off, 32'h21);
    // Standby entered mid-conversion still lets it finish.
    notes.push_back(3'h3);
    start_event_in <= 1;
    @(posedge ref_clk);
    start_event_in <= 0;
    sleep_standby <= 1;
    do @(posedge ref_clk); while (result_ready_event !== 1'b1);
    k = n_starts;
    start_event_in <= 1;
    repeat (2) @(posedge ref_clk);
    start_event_in <= 0;
    repeat (20) @(posedge ref_clk);
    check(n_starts - k, 32'h0);
    check(analog_keep_on, 32'h0);
    wr(primary_control_off, 32'hA1);
    repeat (2) @(posedge ref_clk);
    check(analog_keep_on, 32'h1);
    convert(16'h0033, 3'h3, 1);
    sleep_standby <= 0;
    tidy();
    $display("test sleep done");
    k = n_aborts;
    start_event_in <= 1;
    @(posedge ref_clk);
    start_event_in <= 0;
    repeat (3) @(posedge ref_clk);
    sleep_powerdown <= 1;
    repeat (4) @(posedge ref_clk);
    sleep_powerdown <= 0;
    repeat (15) @(posedge ref_clk);
    check(n_aborts - k, 32'h1);
    $display("test power-down done");
    wr(command_off, 32'h0);
    // A start offered while the clock enable is low must be lost.
    k = n_starts;
    clk_en <= 0;
    software_start <= 1;
    @(posedge ref_clk);
    software_start <= 0;
    repeat (3) @(posedge ref_clk);
    clk_en <= 1;
    repeat (20) @(posedge ref_clk);
    check(n_starts - k, 32'h0);
    wr(debug_control_off, 32'h1);
    debug_halt <= 1;
    convert(16'h0044, 3'h3, 0);
    check(converter_halted, 32'h0);
    debug_halt <= 0;
    wr(debug_control_off, 32'h0);
    notes.push_back(3'h3);
    software_start <= 1;
    @(posedge ref_clk);
    software_start <= 0;
    debug_halt <= 1;
    do @(posedge ref_clk); while (result_ready_event !== 1'b1);
    repeat (3) @(posedge ref_clk);
    check(converter_halted, 32'h1);
    debug_halt <= 0;
    $display("test debug done");
    check(notes.size(), 32'h0);
    conclude();
  end
endmodule // tb
`default_nettype wire
